// file: lac_consts.svh
`ifndef LAC_CONSTS_SVH
`define LAC_CONSTS_SVH

// link pins: data pairs from the converter side
`define LAC_NUM_PAIRS 35
// parallel formats: bit-wise and sample-wise resolutions
`define LAC_BW_BITS 16
`define LAC_SW_BITS 14
// serial formats: data pairs used by the deserializer
`define LAC_SER_LANES 8
// serial resolutions in bits per sample
`define LAC_RES12_BITS 5'h0C
`define LAC_RES14_BITS 5'h0E
`define LAC_RES16_BITS 5'h10
`define LAC_CNT_ONE 5'h01
`define LAC_CNT_MAX 5'h1F
// stored word width and memory depth in samples
`define LAC_WORD_BITS 16
`define LAC_ADDR_BITS 29
`define LAC_LEN_BITS 30
`define LAC_MEM_DEPTH 30'h2000_0000
`define LAC_LEN_ONE 30'h0000_0001
`define LAC_ADDR_ONE 29'h0000_0001
// crossing fifo address width
`define LAC_FIFO_AW 3
// spi clock: least half period in ns, master clock period in ns
`define LAC_SPI_HALF_NS 20
`define LAC_MCLK_NS 10
`define LAC_SPI_HALF_CYC ((`LAC_SPI_HALF_NS + `LAC_MCLK_NS - 1) / `LAC_MCLK_NS)

`endif

// file: lac_pkg.sv
package lac_pkg;

  typedef enum logic {
    LAC_FMT_BITWISE = 1'h0,
    LAC_FMT_SAMPLEWISE = 1'h1
  } lac_par_fmt_t;

  typedef enum logic [1:0] {
    LAC_RES12 = 2'h0,
    LAC_RES14 = 2'h1,
    LAC_RES16 = 2'h2
  } lac_res_t;

  typedef enum logic [1:0] {
    LAC_RD_IDLE = 2'h0,
    LAC_RD_FETCH = 2'h1,
    LAC_RD_SHIFT = 2'h3,
    LAC_RD_FINISH = 2'h2
  } lac_rd_t;

endpackage

// file: lac_capture.sv
`timescale 1ns/1ns
`include "lac_consts.svh"
module lac_capture
  import lac_pkg::*;
#(
  parameter bit SERIAL_IMAGE = 1'h1,
  parameter int NUM_PAIRS = `LAC_NUM_PAIRS,
  parameter int BW_BITS = `LAC_BW_BITS,
  parameter int SW_BITS = `LAC_SW_BITS,
  parameter int SER_LANES = `LAC_SER_LANES,
  parameter int FIFO_AW = `LAC_FIFO_AW,
  parameter int SPI_HALF = `LAC_SPI_HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic linkClk,
  input wire logic frameClk,
  input wire logic [NUM_PAIRS-1:0] dataPair,
  input wire lac_par_fmt_t parFormat,
  input wire lac_res_t serRes,
  input wire logic serTwoWire,
  input wire logic capStart,
  input wire logic [`LAC_LEN_BITS-1:0] capLen,
  output logic capBusy,
  output logic overrun,
  output logic memWrValid,
  output logic [`LAC_ADDR_BITS-1:0] memWrAddr,
  output logic [`LAC_WORD_BITS-1:0] memWrData,
  input wire logic memWrReady,
  input wire logic rdStart,
  input wire logic [`LAC_LEN_BITS-1:0] rdLen,
  output logic rdBusy,
  output logic memRdReq,
  output logic [`LAC_ADDR_BITS-1:0] memRdAddr,
  input wire logic memRdValid,
  input wire logic [`LAC_WORD_BITS-1:0] memRdData,
  output logic spiCsN,
  output logic spiSclk,
  output logic spiMosi
);

  localparam int EW = 2 * `LAC_WORD_BITS + 1;

  // ---------------- link clock domain ----------------
  logic [1:0] linkRstSync;
  logic linkRst;
  logic [5:0] cfgMeta, cfgLink;
  logic linkRun, runPrev, ovrLink, lossLink;
  lac_par_fmt_t cfgFmt;
  lac_res_t cfgRes;
  logic cfgTwo;
  logic [NUM_PAIRS-1:0] posCap, negCap;
  logic posFrm, negFrm;
  logic linkPush, linkTwo;
  logic [`LAC_WORD_BITS-1:0] lw0, lw1;
  logic [EW-1:0] fifoMem [2**FIFO_AW];
  logic [FIFO_AW:0] wBin, wGray, wBinNext, rGrayMeta, rGraySync, rGray;
  logic fifoFull, fifoWr;
  logic capArm;
  lac_rd_t rdState;

  // reset asserts at once, releases on the link clock
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) linkRstSync <= 2'h3;
    else linkRstSync <= {linkRstSync[0], 1'h0};
  end
  assign linkRst = linkRstSync[1];

  // static configuration and arm level brought over as levels
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      cfgMeta <= 6'h00;
      cfgLink <= 6'h00;
    end else begin
      cfgMeta <= {clkEn, capArm, parFormat, serRes, serTwoWire};
      cfgLink <= cfgMeta;
    end
  end
  assign linkRun = cfgLink[5] & cfgLink[4];
  assign cfgFmt = lac_par_fmt_t'(cfgLink[3]);
  assign cfgRes = lac_res_t'(cfgLink[2:1]);
  assign cfgTwo = cfgLink[0];

  // both-edge capture of all data pairs and the frame clock
  always_ff @(posedge linkClk) begin
    posCap <= dataPair;
    posFrm <= frameClk;
  end
  always_ff @(negedge linkClk) begin
    negCap <= dataPair;
    negFrm <= frameClk;
  end

  generate
    if (!SERIAL_IMAGE) begin : g_par
      localparam int BW_LANES = BW_BITS / 2;
      logic [`LAC_WORD_BITS-1:0] bwWord;
      always_comb begin
        bwWord = 16'h0000;
        for (int i = 0; i < BW_LANES; i++) begin
          bwWord[2*i+1] = posCap[i];
          bwWord[2*i] = negCap[i];
        end
      end
      assign linkPush = linkRun;
      assign linkTwo = (cfgFmt == LAC_FMT_SAMPLEWISE);
      assign lw0 = linkTwo ? 16'(posCap[SW_BITS-1:0]) : bwWord;
      assign lw1 = linkTwo ? 16'(negCap[SW_BITS-1:0]) : 16'h0000;
      assign lossLink = linkPush & fifoFull;

      sw_fall_a: assert property (@(negedge linkClk) disable iff (linkRst)
        (cfgFmt == LAC_FMT_SAMPLEWISE) |-> negCap[SW_BITS-1:0] == $past(dataPair[SW_BITS-1:0]))
        else $error("falling edge sample not captured");
      sw_rise_a: assert property (@(posedge linkClk) disable iff (linkRst)
        (linkPush && linkTwo) |-> lw0 == 16'($past(dataPair[SW_BITS-1:0])))
        else $error("rising edge sample mismatch");
      bw_odd_a: assert property (@(posedge linkClk) disable iff (linkRst)
        (linkPush && !linkTwo) |-> (lw0[1] == $past(dataPair[0])
          && lw0[BW_BITS-1] == $past(dataPair[BW_LANES-1])))
        else $error("odd bits not from rising edge");
    end else begin : g_ser
      localparam int LANES = SER_LANES;
      localparam int CW = $clog2(LANES);
      localparam int IW = CW + 1;
      logic [`LAC_WORD_BITS-1:0] sh [LANES];
      logic [`LAC_WORD_BITS-1:0] shMid [LANES];
      logic [`LAC_WORD_BITS-1:0] snap [LANES];
      logic [`LAC_WORD_BITS-1:0] chWord [LANES];
      logic [`LAC_WORD_BITS-1:0] hold [LANES];
      logic [`LAC_WORD_BITS-1:0] resMask, halfMask;
      logic [4:0] bitCnt, cntMid, cntBase, cntEnd, resBits, bpl;
      logic frmPrev, locked, riseMid, riseEnd, doneMid, doneEnd, wordDone;
      logic [IW-1:0] pend, chans;
      logic [CW-1:0] idx;

      always_comb begin
        resBits = (cfgRes == LAC_RES12) ? `LAC_RES12_BITS :
          (cfgRes == LAC_RES14) ? `LAC_RES14_BITS : `LAC_RES16_BITS;
        bpl = cfgTwo ? (resBits >> 1) : resBits;
        chans = cfgTwo ? IW'(LANES / 2) : IW'(LANES);
        // one counter and one frame reference for every lane
        riseMid = posFrm & ~frmPrev;
        riseEnd = negFrm & ~posFrm;
        cntMid = riseMid ? `LAC_CNT_ONE : (bitCnt == `LAC_CNT_MAX) ? bitCnt : bitCnt + `LAC_CNT_ONE;
        doneMid = (locked | riseMid) && cntMid == bpl;
        cntBase = doneMid ? 5'h00 : cntMid;
        cntEnd = riseEnd ? `LAC_CNT_ONE : (cntBase == `LAC_CNT_MAX) ? cntBase : cntBase + `LAC_CNT_ONE;
        doneEnd = (locked | riseMid | riseEnd) && cntEnd == bpl;
        wordDone = doneMid | doneEnd;
        resMask = 16'hFFFF >> (5'h10 - resBits);
        halfMask = 16'hFFFF >> (5'h10 - bpl);
      end

      always_comb begin
        for (int l = 0; l < LANES; l++) begin
          shMid[l] = {sh[l][14:0], posCap[l]};
          snap[l] = doneMid ? shMid[l] : {shMid[l][14:0], negCap[l]};
          chWord[l] = snap[l] & resMask;
        end
        if (cfgTwo) begin
          // even lane of a pair holds the upper half of the word
          for (int c = 0; c < LANES / 2; c++) begin
            chWord[c] = ((snap[2*c] & halfMask) << bpl) | (snap[2*c+1] & halfMask);
          end
          for (int c = LANES / 2; c < LANES; c++) begin
            chWord[c] = 16'h0000;
          end
        end
      end

      always_ff @(posedge linkClk) begin
        for (int l = 0; l < LANES; l++) begin
          sh[l] <= {shMid[l][14:0], negCap[l]};
        end
        if (wordDone) hold <= chWord;
      end

      always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
          bitCnt <= 5'h00;
          frmPrev <= 1'h0;
          locked <= 1'h0;
        end else begin
          bitCnt <= doneEnd ? 5'h00 : cntEnd;
          frmPrev <= negFrm;
          locked <= locked | riseMid | riseEnd;
        end
      end

      // hand the channel words of one frame to the fifo, two per cycle
      always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
          pend <= '0;
          idx <= '0;
        end else if (!linkRun) begin
          pend <= '0;
        end else if (wordDone) begin
          pend <= chans;
          idx <= '0;
        end else if (linkPush) begin
          pend <= linkTwo ? pend - IW'(2) : pend - IW'(1);
          idx <= idx + CW'(2);
        end
      end
      assign linkPush = (pend != '0);
      assign linkTwo = (pend >= IW'(2));
      assign lw0 = hold[idx];
      assign lw1 = hold[idx | CW'(1)];
      assign lossLink = (linkPush & fifoFull) | (linkRun & wordDone & linkPush);

      ser_realign_a: assert property (@(posedge linkClk) disable iff (linkRst)
        riseEnd |=> bitCnt == `LAC_CNT_ONE)
        else $error("bit counter not realigned on frame edge");
      ser_chans_a: assert property (@(posedge linkClk) disable iff (linkRst)
        (wordDone && linkRun) |=> pend == $past(chans))
        else $error("wrong channel count after frame");
      ser_bpl_a: assert property (@(posedge linkClk) disable iff (linkRst)
        bpl inside {5'h06, 5'h07, 5'h08, 5'h0C, 5'h0E, 5'h10})
        else $error("illegal bits per lane");
    end
  endgenerate

  // loss flag clears when a new capture starts on the link side
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      ovrLink <= 1'h0;
      runPrev <= 1'h0;
    end else begin
      runPrev <= linkRun;
      if (lossLink) ovrLink <= 1'h1;
      else if (linkRun && !runPrev) ovrLink <= 1'h0;
    end
  end

  // write side of the crossing fifo
  assign wBinNext = wBin + (FIFO_AW+1)'(1);
  assign fifoFull = (wGray == {~rGraySync[FIFO_AW:FIFO_AW-1], rGraySync[FIFO_AW-2:0]});
  assign fifoWr = linkPush & ~fifoFull;
  always_ff @(posedge linkClk) begin
    if (fifoWr) fifoMem[wBin[FIFO_AW-1:0]] <= {linkTwo, lw1, lw0};
  end
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      wBin <= '0;
      wGray <= '0;
      rGrayMeta <= '0;
      rGraySync <= '0;
    end else begin
      rGrayMeta <= rGray;
      rGraySync <= rGrayMeta;
      if (fifoWr) begin
        wBin <= wBinNext;
        wGray <= wBinNext ^ (wBinNext >> 1);
      end
    end
  end

  // ---------------- master clock domain ----------------
  logic [FIFO_AW:0] rBin, rBinNext, wGrayMeta, wGraySync;
  logic ovrMeta, fifoEmpty, half, slotFree, take, issue, entryLast;
  logic [EW-1:0] entry;
  logic [`LAC_LEN_BITS-1:0] capCnt, capLenR, rdLeft;
  logic [`LAC_WORD_BITS-1:0] shReg;
  logic [3:0] bitIdx;
  logic [7:0] divCnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wGrayMeta <= '0;
      wGraySync <= '0;
      ovrMeta <= 1'h0;
      overrun <= 1'h0;
    end else if (clkEn) begin
      wGrayMeta <= wGray;
      wGraySync <= wGrayMeta;
      ovrMeta <= ovrLink;
      overrun <= ovrMeta;
    end
  end

  assign fifoEmpty = (rGray == wGraySync);
  assign entry = fifoMem[rBin[FIFO_AW-1:0]];
  assign rBinNext = rBin + (FIFO_AW+1)'(1);
  assign slotFree = ~memWrValid | memWrReady;
  assign take = clkEn & slotFree & ~fifoEmpty;
  assign issue = take & capArm;
  assign entryLast = half | ~entry[EW-1];

  // entries left over after a capture ends are drained and dropped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rBin <= '0;
      rGray <= '0;
      half <= 1'h0;
    end else if (take) begin
      half <= ~entryLast;
      if (entryLast) begin
        rBin <= rBinNext;
        rGray <= rBinNext ^ (rBinNext >> 1);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      capArm <= 1'h0;
      capCnt <= '0;
      capLenR <= '0;
    end else if (clkEn) begin
      if (!capArm && capStart && capLen != '0 && rdState == LAC_RD_IDLE) begin
        capArm <= 1'h1;
        capCnt <= '0;
        capLenR <= (capLen > `LAC_MEM_DEPTH) ? `LAC_MEM_DEPTH : capLen;
      end else if (issue) begin
        capCnt <= capCnt + `LAC_LEN_ONE;
        if (capCnt + `LAC_LEN_ONE >= capLenR) capArm <= 1'h0;
      end
    end
  end
  assign capBusy = capArm;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      memWrValid <= 1'h0;
      memWrAddr <= '0;
      memWrData <= 16'h0000;
    end else if (clkEn) begin
      if (issue) begin
        memWrValid <= 1'h1;
        memWrAddr <= capCnt[`LAC_ADDR_BITS-1:0];
        memWrData <= half ? entry[31:16] : entry[15:0];
      end else if (memWrReady) begin
        memWrValid <= 1'h0;
      end
    end
  end

  // readout: fetch a word, shift it msb first, spi mode 0
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdState <= LAC_RD_IDLE;
      memRdAddr <= '0;
      rdLeft <= '0;
      memRdReq <= 1'h0;
      spiCsN <= 1'h1;
      spiSclk <= 1'h0;
      spiMosi <= 1'h0;
      shReg <= 16'h0000;
      bitIdx <= 4'h0;
      divCnt <= 8'h00;
    end else if (clkEn) begin
      case (rdState)
        LAC_RD_IDLE: begin
          if (rdStart && rdLen != '0 && !capArm) begin
            memRdAddr <= '0;
            rdLeft <= (rdLen > `LAC_MEM_DEPTH) ? `LAC_MEM_DEPTH : rdLen;
            memRdReq <= 1'h1;
            rdState <= LAC_RD_FETCH;
          end
        end
        LAC_RD_FETCH: begin
          if (memRdValid) begin
            memRdReq <= 1'h0;
            shReg <= memRdData;
            spiMosi <= memRdData[15];
            bitIdx <= 4'hF;
            spiCsN <= 1'h0;
            divCnt <= 8'h00;
            rdState <= LAC_RD_SHIFT;
          end
        end
        LAC_RD_SHIFT: begin
          if (divCnt == 8'(SPI_HALF - 1)) begin
            divCnt <= 8'h00;
            spiSclk <= ~spiSclk;
            if (spiSclk) begin
              if (bitIdx == 4'h0) begin
                rdLeft <= rdLeft - `LAC_LEN_ONE;
                if (rdLeft == `LAC_LEN_ONE) begin
                  rdState <= LAC_RD_FINISH;
                end else begin
                  memRdAddr <= memRdAddr + `LAC_ADDR_ONE;
                  memRdReq <= 1'h1;
                  rdState <= LAC_RD_FETCH;
                end
              end else begin
                bitIdx <= bitIdx - 4'h1;
                spiMosi <= shReg[bitIdx - 4'h1];
              end
            end
          end else begin
            divCnt <= divCnt + 8'h01;
          end
        end
        LAC_RD_FINISH: begin
          spiCsN <= 1'h1;
          rdState <= LAC_RD_IDLE;
        end
        default: rdState <= LAC_RD_IDLE;
      endcase
    end
  end
  assign rdBusy = (rdState != LAC_RD_IDLE);

  wr_addr_step_a: assert property (@(posedge mclk) disable iff (rst)
    ((memWrValid && memWrReady && capArm && clkEn) ##1 memWrValid)
      |-> memWrAddr == $past(memWrAddr) + `LAC_ADDR_ONE)
    else $error("write address did not step by one");
  cap_limit_a: assert property (@(posedge mclk) disable iff (rst)
    capArm |-> (capCnt < capLenR && capLenR <= `LAC_MEM_DEPTH))
    else $error("capture count beyond length");
  spi_cs_a: assert property (@(posedge mclk) disable iff (rst)
    (rdState == LAC_RD_SHIFT) |-> !spiCsN)
    else $error("chip select high while shifting");
  spi_edge_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(spiSclk) |-> ($past(divCnt) == 8'(SPI_HALF - 1) && $past(rdState) == LAC_RD_SHIFT))
    else $error("spi clock edge out of step");
  rd_fetch_a: assert property (@(posedge mclk) disable iff (rst)
    (rdState == LAC_RD_FETCH && memRdValid && clkEn)
      |=> (rdState == LAC_RD_SHIFT && spiMosi == $past(memRdData[15]) && !spiCsN))
    else $error("fetched word not started on spi");

endmodule // lac_capture

// file: lac_adc_model.sv
`timescale 1ns/1ns
`include "lac_consts.svh"
module lac_adc_model (
  output logic linkClk,
  output logic frameClk,
  output logic [`LAC_NUM_PAIRS-1:0] dataPair
);
  localparam logic [15:0] PAT = 16'hA5C3;

  initial begin
    linkClk = 1'h0;
    frameClk = 1'h0;
    dataPair = '0;
  end

  // one burst of frames; the bit clock stands still between bursts
  task automatic send(input int frames, input int bits, input bit twoWire);
    int bpl;
    int chans;
    int n;
    logic [15:0] v;
    logic [`LAC_NUM_PAIRS-1:0] d;
    bpl = twoWire ? bits / 2 : bits;
    chans = twoWire ? 4 : 8;
    n = 0;
    #3;
    for (int f = 0; f < frames; f++) begin
      for (int k = 0; k < bpl; k++) begin
        // unused pairs change every bit
        d = ~dataPair;
        frameClk = (k < (bpl + 1) / 2);
        for (int c = 0; c < chans; c++) begin
          v = 16'((f * chans + c) ^ PAT);
          if (twoWire) begin
            d[2*c] = v[bits-1-k];
            d[2*c+1] = v[bits/2-1-k];
          end else begin
            d[c] = v[bits-1-k];
          end
        end
        dataPair = d;
        // lines change midway between edges, one shared clock for all lanes
        #20;
        linkClk = ~linkClk;
        #20;
        n++;
      end
    end
    frameClk = 1'h0;
    dataPair = ~dataPair;
    if (n % 2 == 1) begin
      #20;
      linkClk = ~linkClk;
      #20;
    end
  endtask

  // parallel burst: rising edge carries odd bits or a whole sample, falling edge even bits or the next sample
  task automatic send_par(input int cycles, input bit sw);
    logic [`LAC_NUM_PAIRS-1:0] d;
    logic [15:0] v;
    #3;
    for (int k = 0; k < 2 * cycles; k++) begin
      v = 16'((sw ? k : k / 2) ^ PAT);
      d = ~dataPair;
      for (int i = 0; i < `LAC_SW_BITS; i++) begin
        d[i] = sw ? v[i] : (i < `LAC_BW_BITS / 2 ? v[2*i+1-k%2] : 1'h0);
      end
      dataPair = d;
      #20;
      linkClk = ~linkClk;
      #20;
    end
  endtask
endmodule // lac_adc_model

// file: lvds_adc_capture_deserializer_bench.sv
`timescale 1ns/1ns
`include "lac_consts.svh"
module lvds_adc_capture_deserializer_bench;
  import lac_pkg::*;
  localparam logic [15:0] PAT = 16'hA5C3;
  logic mclk, rst, clkEn, linkClk, frameClk;
  logic [`LAC_NUM_PAIRS-1:0] dataPair;
  lac_par_fmt_t parFormat;
  lac_res_t serRes;
  logic serTwoWire, capStart, capBusy, overrun, memWrValid, memWrReady;
  logic [`LAC_LEN_BITS-1:0] capLen, rdLen;
  logic [`LAC_ADDR_BITS-1:0] memWrAddr, memRdAddr;
  logic [`LAC_WORD_BITS-1:0] memWrData, memRdData;
  logic rdStart, rdBusy, memRdReq, memRdValid, spiCsN, spiSclk, spiMosi;
  logic [15:0] mem [0:63];
  int num_errors, cmp_count;
  logic pCapStart, pBusy, pOverrun, pValid;
  logic [`LAC_ADDR_BITS-1:0] pAddr;
  logic [`LAC_WORD_BITS-1:0] pData;

  always #5 mclk = ~mclk;

  lac_adc_model adc_u (.linkClk(linkClk), .frameClk(frameClk), .dataPair(dataPair));

  lac_capture #(.SERIAL_IMAGE(1'h1)) dut_u (
    .mclk(mclk), .rst(rst), .clkEn(clkEn), .linkClk(linkClk), .frameClk(frameClk),
    .dataPair(dataPair), .parFormat(parFormat), .serRes(serRes), .serTwoWire(serTwoWire),
    .capStart(capStart), .capLen(capLen), .capBusy(capBusy), .overrun(overrun),
    .memWrValid(memWrValid), .memWrAddr(memWrAddr), .memWrData(memWrData), .memWrReady(memWrReady),
    .rdStart(rdStart), .rdLen(rdLen), .rdBusy(rdBusy), .memRdReq(memRdReq), .memRdAddr(memRdAddr),
    .memRdValid(memRdValid), .memRdData(memRdData), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi)
  );

  // parallel image on the same link; readout is covered by the serial image
  lac_capture #(.SERIAL_IMAGE(1'h0)) dut_par_u (
    .mclk(mclk), .rst(rst), .clkEn(clkEn), .linkClk(linkClk), .frameClk(frameClk),
    .dataPair(dataPair), .parFormat(parFormat), .serRes(serRes), .serTwoWire(serTwoWire),
    .capStart(pCapStart), .capLen(capLen), .capBusy(pBusy), .overrun(pOverrun),
    .memWrValid(pValid), .memWrAddr(pAddr), .memWrData(pData), .memWrReady(memWrReady),
    .rdStart(1'h0), .rdLen(30'h0000_0000), .rdBusy(), .memRdReq(), .memRdAddr(),
    .memRdValid(1'h0), .memRdData(16'h0000), .spiCsN(), .spiSclk(), .spiMosi()
  );

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_over();
    num_errors++;
    $display("[FAIL] t=%0t wait bound used up got=%h exp=%h", $time, 1'h0, 1'h1);
    end_sim();
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  // arms a capture, streams frames and judges every stored word
  task automatic run_capture(input lac_res_t res, input bit tw, input int len);
    int bits, chans, mask, got, idx0, lim, frames;
    bits = (res == LAC_RES12) ? 12 : (res == LAC_RES14) ? 14 : 16;
    chans = tw ? 4 : 8;
    frames = len / chans + 4;
    mask = (1 << bits) - 1;
    got = 0;
    lim = 0;
    idx0 = 0;
    serRes = res;
    serTwoWire = tw;
    capLen = 30'(len);
    capStart = 1'h1;
    tick();
    capStart = 1'h0;
    check_flag(capBusy, 1'h1);
    fork
      adc_u.send(frames, bits, tw);
      begin
        while ((capBusy || memWrValid) && lim < 20000) begin
          @(posedge mclk);
          if (memWrValid && memWrReady) begin
            if (got == 0) begin
              idx0 = int'((memWrData ^ PAT) & mask);
              check_flag(idx0 < frames * chans, 1'h1);
            end
            check_val(memWrAddr, got);
            check_val(memWrData, ((idx0 + got) ^ PAT) & mask);
            mem[got] = memWrData;
            got++;
          end
          #1;
          // memory stalls one cycle in three
          memWrReady = (lim % 3 != 0);
          lim++;
        end
      end
    join
    if (lim >= 20000) begin
      wait_over();
    end
    check_val(got, len);
    check_flag(overrun, 1'h0);
    memWrReady = 1'h1;
  endtask

  task automatic test_refuse();
    capLen = 30'h0000_0000;
    capStart = 1'h1;
    tick();
    capStart = 1'h0;
    repeat (3) tick();
    check_flag(capBusy, 1'h0);
    $display("test refuse done");
  endtask

  task automatic test_one_wire();
    run_capture(LAC_RES12, 1'h0, 13);
    run_capture(LAC_RES14, 1'h0, 16);
    run_capture(LAC_RES16, 1'h0, 9);
    $display("test one wire done");
  endtask

  task automatic test_two_wire();
    run_capture(LAC_RES14, 1'h1, 12);
    run_capture(LAC_RES16, 1'h1, 7);
    $display("test two wire done");
  endtask

  // reads back three words over spi, a capture request meanwhile is ignored
  task automatic test_readout();
    int words, bitCnt, waitCnt, lim, nrd;
    logic [15:0] sh;
    logic prevSclk, sawBusy;
    words = 0;
    bitCnt = 0;
    waitCnt = 0;
    lim = 0;
    nrd = 0;
    sh = 16'h0000;
    prevSclk = 1'h0;
    sawBusy = 1'h0;
    rdLen = 30'h0000_0003;
    rdStart = 1'h1;
    tick();
    rdStart = 1'h0;
    check_flag(memRdReq, 1'h1);
    check_flag(rdBusy, 1'h1);
    capLen = 30'h0000_0005;
    capStart = 1'h1;
    while ((rdBusy || !spiCsN) && lim < 5000) begin
      @(posedge mclk);
      if (capBusy) begin
        sawBusy = 1'h1;
      end
      if (spiSclk && !prevSclk && !spiCsN) begin
        sh = {sh[14:0], spiMosi};
        bitCnt++;
        if (bitCnt == 16) begin
          check_val(sh, mem[words]);
          words++;
          bitCnt = 0;
        end
      end
      prevSclk = spiSclk;
      #1;
      capStart = 1'h0;
      if (memRdReq && !memRdValid && waitCnt == 2) begin
        check_val(memRdAddr, nrd);
        memRdData = mem[memRdAddr[5:0]];
        memRdValid = 1'h1;
        nrd++;
        waitCnt = 0;
      end else begin
        if (memRdReq && !memRdValid) begin
          waitCnt++;
        end
        memRdValid = 1'h0;
        memRdData = ~memRdData;
      end
      lim++;
    end
    if (lim >= 5000) begin
      wait_over();
    end
    check_val(words, 3);
    check_flag(sawBusy, 1'h0);
    check_flag(spiSclk, 1'h0);
    $display("test readout done");
  endtask

  // parallel capture: consecutive samples stored in order, odd sample-wise length drops the last half entry
  task automatic test_parallel(input bit sw, input int len);
    int got, idx0, lim, mask;
    mask = sw ? (1 << `LAC_SW_BITS) - 1 : (1 << `LAC_BW_BITS) - 1;
    got = 0;
    lim = 0;
    idx0 = 0;
    parFormat = sw ? LAC_FMT_SAMPLEWISE : LAC_FMT_BITWISE;
    capLen = 30'(len);
    pCapStart = 1'h1;
    tick();
    pCapStart = 1'h0;
    check_flag(pBusy, 1'h1);
    fork
      adc_u.send_par(sw ? len / 2 + 6 : len + 6, sw);
      begin
        while ((pBusy || pValid) && lim < 20000) begin
          @(posedge mclk);
          if (pValid && memWrReady) begin
            if (got == 0) begin
              idx0 = int'((pData ^ PAT) & mask);
              check_flag(idx0 < 8, 1'h1);
            end
            check_val(pAddr, got);
            check_val(pData, ((idx0 + got) ^ PAT) & mask);
            got++;
          end
          #1;
          memWrReady = (lim % 3 != 0);
          lim++;
        end
      end
    join
    if (lim >= 20000) begin
      wait_over();
    end
    check_val(got, len);
    check_flag(pOverrun, 1'h0);
    memWrReady = 1'h1;
    $display("test parallel done");
  endtask

  initial begin
    mclk = 1'h0;
    rst = 1'h1;
    clkEn = 1'h1;
    parFormat = LAC_FMT_BITWISE;
    serRes = LAC_RES12;
    serTwoWire = 1'h0;
    capStart = 1'h0;
    capLen = 30'h0000_0000;
    pCapStart = 1'h0;
    memWrReady = 1'h1;
    rdStart = 1'h0;
    rdLen = 30'h0000_0000;
    memRdValid = 1'h0;
    memRdData = 16'h0000;
    num_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'h0;
    check_flag(spiCsN, 1'h1);
    test_refuse();
    test_one_wire();
    test_two_wire();
    test_readout();
    test_parallel(1'h1, 11);
    test_parallel(1'h0, 9);
    end_sim();
  end
endmodule // lvds_adc_capture_deserializer_bench
